// ===== rtl/i2c_status_defs.vh
`ifndef I2C_STATUS_DEFS_VH
`define I2C_STATUS_DEFS_VH

// Register map, byte addresses.
`define STS_ADDR_W         8
`define STS_OFFSET         8'h04

// Field positions inside the status word.
`define STS_PHASE_HI       11
`define STS_PHASE_LO       8
`define STS_EXT_CLK_BIT    5
`define STS_TX_FULL_BIT    4
`define STS_TX_EMPTY_BIT   3
`define STS_RX_FULL_BIT    2
`define STS_RX_EMPTY_BIT   1
`define STS_BUSY_BIT       0

// Reset values of the fields.
`define STS_PHASE_RST      4'h0
`define STS_EXT_CLK_RST    1'h0
`define STS_TX_FULL_RST    1'h0
`define STS_TX_EMPTY_RST   1'h1
`define STS_RX_FULL_RST    1'h0
`define STS_RX_EMPTY_RST   1'h1
`define STS_BUSY_RST       1'h0

// Stage codes presented by the protocol engine.
`define STG_W              4
`define STG_IDLE           4'h0
`define STG_ADDR           4'h1
`define STG_ADDR_ACK       4'h2
`define STG_EXT_ADDR       4'h3
`define STG_EXT_ACK        4'h4
`define STG_TX_DATA        4'h5
`define STG_TX_DATA_ACK    4'h6
`define STG_RX_DATA        4'h7
`define STG_RX_DATA_ACK    4'h8
`define STG_NACK           4'h9

// Phase codes reported to software.
`define PH_IDLE            4'h0
`define PH_M_ADDR          4'h1
`define PH_M_ADDR_ACK      4'h2
`define PH_M_EXT_ADDR      4'h3
`define PH_M_EXT_ACK       4'h4
`define PH_S_ADDR          4'h5
`define PH_S_ADDR_ACK      4'h6
`define PH_S_EXT_ADDR      4'h7
`define PH_S_EXT_ACK       4'h8
`define PH_TX_DATA         4'h9
`define PH_TX_DATA_ACK     4'ha
`define PH_RX_DATA         4'hb
`define PH_RX_DATA_ACK     4'hc
`define PH_NACK            4'hd
`define PH_OTHERS          4'hf

`endif

// ===== rtl/i2c_line_monitor.v
`timescale 1ns/1ps
`include "i2c_status_defs.vh"

module i2c_line_monitor (
  // Clock and reset.
  input  wire clk_sys,
  input  wire sys_rst,
  // Bus line levels from the pins.
  input  wire scl_pin,
  input  wire sda_pin,
  // Own activity on the clock line.
  input  wire own_scl_low,
  input  wire own_master,
  // Results.
  output reg  bus_busy,
  output reg  ext_clk
);

  reg       scl_meta;
  reg       scl_sync;
  reg       sda_meta;
  reg       sda_sync;
  reg       scl_prev;
  reg       sda_prev;
  reg [2:0] own_low_pipe;
  wire      start_seen;
  wire      stop_seen;
  wire      scl_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers; the first stage is never looked at.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      scl_meta <= 1'h1;
      scl_sync <= 1'h1;
      sda_meta <= 1'h1;
      sda_sync <= 1'h1;
      scl_prev <= 1'h1;
      sda_prev <= 1'h1;
      own_low_pipe <= 3'h0;
    end else begin
      scl_meta <= scl_pin;
      scl_sync <= scl_meta;
      sda_meta <= sda_pin;
      sda_sync <= sda_meta;
      scl_prev <= scl_sync;
      sda_prev <= sda_sync;
      own_low_pipe <= {own_low_pipe[1:0], own_scl_low};
    end
  end

  assign start_seen = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_seen  = scl_sync & scl_prev & ~sda_prev & sda_sync;
  assign scl_fall   = scl_prev & ~scl_sync;

  ////////////////////////////////////////////////////////////////////////////
  // Busy runs from a start to a stop. A falling clock edge that this
  // controller did not cause, seen while it is not master and whether or not busy is set, marks a foreign master.
  // The own-drive pipe matches the synchroniser delay so that our own
  // low phase is not mistaken for a foreign one.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      bus_busy <= `STS_BUSY_RST;
      ext_clk  <= `STS_EXT_CLK_RST;
    end else begin
      if (start_seen)
        bus_busy <= 1'h1;
      else if (stop_seen)
        bus_busy <= 1'h0;
      if (stop_seen || own_master)
        ext_clk <= 1'h0;
      else if (scl_fall && !own_low_pipe[2] && !own_low_pipe[1])
        ext_clk <= 1'h1;
    end
  end

endmodule // i2c_line_monitor

// ===== rtl/i2c_status_reporting.v
// What this block does
// - phase field bits 11:8, reset 0 idle
// - master address stages report 1 to 4
// - slave address stages report 5 to 8
// - data stages report 9 to 12
// - NACK stage 13, 14 never shown
// - foreign transfer in progress reports 15
// - bit 5 shows foreign master driving clock
// - bits 4,3 show transmit FIFO full, empty
// - bits 2,1 show receive FIFO full, empty
// - bit 0 shows bus active
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "i2c_status_defs.vh"

module i2c_status_reporting (
  // Clock and reset.
  input  wire                   clk_sys,
  input  wire                   sys_rst,
  // Register port.
  input  wire [`STS_ADDR_W-1:0] reg_addr,
  input  wire [31:0]            reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [31:0]            reg_rdata,
  // Protocol engine state.
  input  wire [`STG_W-1:0]      engine_stage,
  input  wire                   engine_master,
  input  wire                   own_scl_low,
  // FIFO occupancy.
  input  wire                   tx_fifo_full,
  input  wire                   tx_fifo_empty,
  input  wire                   rx_fifo_full,
  input  wire                   rx_fifo_empty,
  // Bus line pins.
  input  wire                   scl_pin,
  input  wire                   sda_pin,
  // Live status word.
  output wire [31:0]            status_word
);

  wire       bus_busy;
  wire       ext_clk;
  wire [3:0] phase;
  reg  [31:0] live_word;

  ////////////////////////////////////////////////////////////////////////////
  // Maps the engine stage and role to the reported phase code.
  function [3:0] phase_code;
    input [`STG_W-1:0] stage;
    input              master;
    input              busy;
    begin
      case (stage)
        `STG_IDLE:        phase_code = busy ? `PH_OTHERS
                                            : `PH_IDLE;
        `STG_ADDR:        phase_code = master ? `PH_M_ADDR
                                              : `PH_S_ADDR;
        `STG_ADDR_ACK:    phase_code = master ? `PH_M_ADDR_ACK
                                              : `PH_S_ADDR_ACK;
        `STG_EXT_ADDR:    phase_code = master ? `PH_M_EXT_ADDR
                                              : `PH_S_EXT_ADDR;
        `STG_EXT_ACK:     phase_code = master ? `PH_M_EXT_ACK
                                              : `PH_S_EXT_ACK;
        `STG_TX_DATA:     phase_code = `PH_TX_DATA;
        `STG_TX_DATA_ACK: phase_code = `PH_TX_DATA_ACK;
        `STG_RX_DATA:     phase_code = `PH_RX_DATA;
        `STG_RX_DATA_ACK: phase_code = `PH_RX_DATA_ACK;
        `STG_NACK:        phase_code = `PH_NACK;
        // Unknown stages fall back to idle so 14 is never shown.
        default:          phase_code = `PH_IDLE;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  i2c_line_monitor u_line_monitor (
    .clk_sys     (clk_sys),
    .sys_rst     (sys_rst),
    .scl_pin     (scl_pin),
    .sda_pin     (sda_pin),
    .own_scl_low (own_scl_low),
    .own_master  (engine_master),
    .bus_busy    (bus_busy),
    .ext_clk     (ext_clk)
  );

  assign phase = phase_code(engine_stage, engine_master, bus_busy);

  ////////////////////////////////////////////////////////////////////////////
  // The word is built from live signals so each field follows its source
  // in the same cycle; during reset it shows the reset values.
  always @* begin
    live_word = 32'h0;
    if (sys_rst) begin
      live_word[`STS_PHASE_HI:`STS_PHASE_LO] = `STS_PHASE_RST;
      live_word[`STS_EXT_CLK_BIT]  = `STS_EXT_CLK_RST;
      live_word[`STS_TX_FULL_BIT]  = `STS_TX_FULL_RST;
      live_word[`STS_TX_EMPTY_BIT] = `STS_TX_EMPTY_RST;
      live_word[`STS_RX_FULL_BIT]  = `STS_RX_FULL_RST;
      live_word[`STS_RX_EMPTY_BIT] = `STS_RX_EMPTY_RST;
      live_word[`STS_BUSY_BIT]     = `STS_BUSY_RST;
    end else begin
      live_word[`STS_PHASE_HI:`STS_PHASE_LO] = phase;
      live_word[`STS_EXT_CLK_BIT]  = ext_clk;
      live_word[`STS_TX_FULL_BIT]  = tx_fifo_full;
      live_word[`STS_TX_EMPTY_BIT] = tx_fifo_empty;
      live_word[`STS_RX_FULL_BIT]  = rx_fifo_full;
      live_word[`STS_RX_EMPTY_BIT] = rx_fifo_empty;
      live_word[`STS_BUSY_BIT]     = bus_busy;
    end
  end

  assign status_word = live_word;

  ////////////////////////////////////////////////////////////////////////////
  // Reads answer one cycle later; unmapped addresses read zero. Writes
  // have no target, so write data is never stored anywhere.
  always @(posedge clk_sys) begin
    if (sys_rst)
      reg_rdata <= 32'h0;
    else if (reg_rd && reg_addr == `STS_OFFSET)
      reg_rdata <= live_word;
    else
      reg_rdata <= 32'h0;
  end

endmodule // i2c_status_reporting

// ===== testbench/i2c_status_checker.sv
`timescale 1ns/1ps
`include "i2c_status_defs.vh"
module i2c_status_checker (
  // Clock and reset.
  input wire                   clk_sys, sys_rst,
  // Register port and live word.
  input wire [`STS_ADDR_W-1:0] reg_addr,
  input wire [31:0]            reg_wdata, reg_rdata, status_word,
  input wire                   reg_wr, reg_rd,
  // Engine, FIFO flags and pins.
  input wire [`STG_W-1:0]      engine_stage,
  input wire                   engine_master, own_scl_low, scl_pin, sda_pin,
  input wire                   tx_fifo_full, tx_fifo_empty,
  input wire                   rx_fifo_full, rx_fifo_empty
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  wire [3:0] ph = status_word[11:8];
  a_idle_phase: assert property (
    engine_stage == `STG_IDLE && !status_word[0] |-> ph == `PH_IDLE)
    else $error("idle phase wrong");
  a_master_addr: assert property (
    engine_master && engine_stage == `STG_ADDR |-> ph == `PH_M_ADDR)
    else $error("master address phase wrong");
  a_slave_ext: assert property (
    !engine_master && engine_stage == `STG_EXT_ACK |-> ph == `PH_S_EXT_ACK)
    else $error("slave extended ack phase wrong");
  a_rx_phase: assert property (
    engine_stage == `STG_RX_DATA |-> ph == `PH_RX_DATA)
    else $error("receive phase wrong");
  a_no_fourteen: assert property (ph != 4'he)
    else $error("reserved phase shown");
  a_foreign_phase: assert property (
    engine_stage == `STG_IDLE && status_word[0] |-> ph == `PH_OTHERS)
    else $error("foreign phase wrong");
  a_fifo_flags: assert property (
    status_word[4:1] == {tx_fifo_full, tx_fifo_empty,
                         rx_fifo_full, rx_fifo_empty})
    else $error("fifo flags wrong");
  a_busy_start: assert property (
    $fell(sda_pin) && scl_pin |-> ##[1:4] status_word[0])
    else $error("busy not set after start");
  a_busy_stop: assert property (
    $rose(sda_pin) && scl_pin |-> ##[1:4] !status_word[0])
    else $error("busy not cleared after stop");
  a_master_no_ext: assert property (
    engine_master |=> !status_word[5])
    else $error("foreign clock shown while master");
  a_read_word: assert property (
    reg_rd && reg_addr == `STS_OFFSET |=> reg_rdata == $past(status_word))
    else $error("read data wrong");
  a_quiet_rdata: assert property (
    !(reg_rd && reg_addr == `STS_OFFSET) |=> reg_rdata == 32'h0)
    else $error("read data not zero");
  cover property (ph == `PH_OTHERS);
  cover property (status_word[5]);
  cover property (reg_wr && reg_addr == `STS_OFFSET);
endmodule // i2c_status_checker

bind i2c_status_reporting i2c_status_checker u_i2c_status_checker (
  .clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_rdata, .status_word,
  .reg_wr, .reg_rd, .engine_stage, .engine_master, .own_scl_low, .scl_pin,
  .sda_pin, .tx_fifo_full, .tx_fifo_empty, .rx_fifo_full, .rx_fifo_empty);

// ===== testbench/far_bus_master.sv
`timescale 1ns/1ps
module far_bus_master (
  // Bus lines; idle level is the pull-up level.
  output reg scl,
  output reg sda
);
  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end
  task start_cond;
    begin
      sda = 1'h0;
      #40 scl = 1'h0;
    end
  endtask
  // Clocks n bits at an 80 ns period, leaving the clock low.
  task clock_bits(input integer n);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        #20 sda = i[0];
        #20 scl = 1'h1;
        #40 scl = 1'h0;
      end
    end
  endtask
  task stop_cond;
    begin
      #20 sda = 1'h0;
      #20 scl = 1'h1;
      #40 sda = 1'h1;
    end
  endtask
endmodule // far_bus_master

// ===== testbench/i2c_status_reporting_tb_top.sv
`timescale 1ns/1ps
`include "i2c_status_defs.vh"
module i2c_status_reporting_tb_top;
  reg        clk_sys, sys_rst, reg_wr, reg_rd, engine_master, own_scl_low;
  reg [7:0]  reg_addr;
  reg [31:0] reg_wdata;
  reg [3:0]  engine_stage, fl, ph;
  wire [31:0] reg_rdata, status_word;
  wire       scl_pin, sda_pin;
  integer    bad_count, comparisons, s;
  i2c_status_reporting u_i2c_status_reporting (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .engine_stage(engine_stage), .engine_master(engine_master),
    .own_scl_low(own_scl_low), .tx_fifo_full(fl[3]), .tx_fifo_empty(fl[2]),
    .rx_fifo_full(fl[1]), .rx_fifo_empty(fl[0]), .scl_pin(scl_pin),
    .sda_pin(sda_pin), .status_word(status_word));
  far_bus_master u_far_bus_master (.scl(scl_pin), .sda(sda_pin));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task settle;
    begin
      repeat (4) @(posedge clk_sys);
      #1;
    end
  endtask
  task complete_run;
    begin
      $display("compared %0d, bad %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  initial begin
    #200000;
    bad_count = bad_count + 1;
    complete_run;
  end
  initial begin
    {bad_count, comparisons} = 0;
    sys_rst = 1'b1;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = 42'h0;
    {engine_stage, engine_master, own_scl_low, fl} = 10'h005;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(`STS_OFFSET, 32'h0000000a);
    for (s = 0; s < 32; s = s + 1) begin
      @(posedge clk_sys);
      engine_stage <= s[4:1];
      engine_master <= s[0];
      ph = (s < 2 || s > 19) ? 4'h0 :
           (s < 10 && s[0]) ? s[4:1] : s[4:1] + 4'h4;
      rd(`STS_OFFSET, {20'h0, ph, 8'h0a});
    end
    $display("phase test done");
    for (s = 0; s < 16; s = s + 1) begin
      @(posedge clk_sys);
      engine_stage <= 4'h0;
      fl <= s[3:0];
      #1 chk(status_word, s * 2);
    end
    fl <= 4'ha;
    wr(`STS_OFFSET, 32'h00000fff);
    rd(`STS_OFFSET, 32'h00000014);
    rd(8'h08, 32'h0);
    fl <= 4'h5;
    engine_master <= 1'b0;
    $display("flag test done");
    u_far_bus_master.start_cond;
    settle;
    chk(status_word, 32'h00000f2b);
    engine_master <= 1'b1;
    settle;
    chk(status_word, 32'h00000f0b);
    engine_master <= 1'b0;
    sys_rst <= 1'b1;
    fl <= 4'ha;
    settle;
    chk(status_word, 32'h0000000a);
    sys_rst <= 1'b0;
    fl <= 4'h5;
    u_far_bus_master.clock_bits(9);
    u_far_bus_master.stop_cond;
    settle;
    chk(status_word, 32'h0000000a);
    own_scl_low <= 1'b1;
    u_far_bus_master.start_cond;
    u_far_bus_master.clock_bits(2);
    settle;
    chk(status_word, 32'h00000f0b);
    u_far_bus_master.stop_cond;
    own_scl_low <= 1'b0;
    settle;
    chk(status_word, 32'h0000000a);
    $display("bus test done");
    complete_run;
  end
endmodule // i2c_status_reporting_tb_top
